// ---- test/tb_timer_counter_input_capture.sv ----
// Self-checking bench for the timer capture and compare block
`timescale 1ns/1ps
module tb_timer_counter_input_capture;
    logic              clk_sys = 1'b0;
    logic              rstn    = 1'b0;
    tmr_pkg::tmr_cfg_t cfg     = '0;
    logic [7:0]        edge_sel = 8'h00, porta_gp_out = 8'h00, porta_dir = 8'h00;
    logic [4:0]        cmp_wr = 5'h00, cmp_pin_en = 5'h00, cmp_pin_lvl = 5'h00;
    logic [4:0]        ch1_mask = 5'h00, ch1_data = 5'h00;
    logic [15:0]       cmp_wdata = 16'h0000;
    logic [3:0]        cap_hi_rd = 4'h0;
    logic [8:0]        int_en = 9'h1ff, flag_clr = 9'h000;
    logic              wdog_service = 1'b0;
    logic [15:0]       count_ff, cap_ff [4], cmp_ff [5];
    logic [7:0]        pacc_ff, porta_in, porta_out, porta_oe;
    logic [8:0]        flag_ff, irq;
    logic [3:0]        porta_level_ff;
    logic              reset_out_n;
    int                errors = 0, n_checks = 0, cyc = 0;
    int                div [4] = '{1, 4, 8, 16};

    tmr_timer tmr_timer_i (.clk_sys(clk_sys), .rstn(rstn), .cfg(cfg), .edge_sel(edge_sel),
        .porta_in(porta_in), .porta_gp_out(porta_gp_out), .porta_dir(porta_dir),
        .cmp_wr(cmp_wr), .cmp_wdata(cmp_wdata), .cmp_pin_en(cmp_pin_en),
        .cmp_pin_lvl(cmp_pin_lvl), .ch1_mask(ch1_mask), .ch1_data(ch1_data),
        .cap_hi_rd(cap_hi_rd), .int_en(int_en), .flag_clr(flag_clr),
        .wdog_service(wdog_service), .count_ff(count_ff), .cap_ff(cap_ff), .cmp_ff(cmp_ff),
        .pacc_ff(pacc_ff), .flag_ff(flag_ff), .irq(irq), .porta_level_ff(porta_level_ff),
        .porta_out(porta_out), .porta_oe(porta_oe), .reset_out_n(reset_out_n));
    tmr_pin_model pin (.porta_out(porta_out), .porta_oe(porta_oe), .porta_in(porta_in));

    always #5 clk_sys = ~clk_sys;
    // Keep the watchdog fed so it never masks other failures
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        wdog_service <= (cyc % 1000 == 0);
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (e !== g) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    // Capture may land either side of one counter step
    task automatic chk_rng(input string what, input logic [15:0] lo, input logic [15:0] g);
        n_checks++;
        if (g !== lo && g !== lo + 16'h0001) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, lo, g);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cap_test(input int ch, input logic [1:0] code);
        int          b;
        logic [15:0] c0;
        logic        hit;
        b = (ch == 3) ? 3 : 2 - ch;
        edge_sel[2*ch +: 2] = code;
        for (int v = 1; v >= 0; v--) begin
            c0 = count_ff;
            hit = (code == 2'b11) || (code == 2'b01 && v == 1) || (code == 2'b10 && v == 0);
            if (ch == 3 && !cfg.capture4_compare5_select) hit = 1'b0;
            pin.set_pin(b, v[0]);
            cap_hi_rd[ch] = 1'b1;
            tick(1);
            cap_hi_rd[ch] = 1'b0;
            tick(8);
            chk("capture flag", {15'h0, hit}, {15'h0, flag_ff[ch]});
            chk("irq", {15'h0, hit}, {15'h0, irq[ch]});
            chk("pin level", {15'h0, v[0]}, {15'h0, porta_level_ff[b]});
            if (hit) chk_rng("capture value", c0, cap_ff[ch]);
            flag_clr[ch] = 1'b1;
            tick(1);
            flag_clr[ch] = 1'b0;
        end
        edge_sel[2*ch +: 2] = 2'b00;
    endtask

    initial begin
        logic [15:0] w, c0;
        int          n;
        void'($urandom(32'hb876));
        tick(4);
        chk("count at reset", 16'h0000, count_ff);
        chk("compare at reset", 16'hffff, cmp_ff[4]);
        chk("flags at reset", 16'h0000, {7'h0, flag_ff});
        chk("reset out", 16'h0001, {15'h0, reset_out_n});
        rstn = 1'b1;
        $display("test done: reset");
        // Values kept high so no compare match can disturb the flags
        for (int i = 0; i < 5; i++) begin
            w = 16'($urandom) | 16'h8000;
            cmp_wdata = w;
            cmp_wr[i] = 1'b1;
            tick(1);
            cmp_wr[i] = 1'b0;
            tick(1);
            chk("compare reg", w, cmp_ff[i]);
        end
        cfg.capture4_compare5_select = 1'b1;
        cmp_wdata = 16'h9abc;
        cmp_wr[4] = 1'b1;
        tick(1);
        cmp_wr[4] = 1'b0;
        tick(1);
        chk("shared reg write", w, cmp_ff[4]);
        cfg.capture4_compare5_select = 1'b0;
        $display("test done: compare writes");
        cmp_pin_en[1] = 1'b1;
        cmp_pin_lvl[1] = 1'b1;
        tick(1);
        chk("pin 4 compare out", 16'h0001, {15'h0, porta_out[4]});
        chk("pin 4 enable", 16'h0001, {15'h0, porta_oe[4]});
        ch1_mask[1] = 1'b1;
        tick(1);
        chk("pin 4 ch1 out", 16'h0000, {15'h0, porta_out[4]});
        ch1_mask[1] = 1'b0;
        cmp_pin_en[1] = 1'b0;
        cmp_pin_lvl[1] = 1'b0;
        tick(1);
        chk("pin 4 released", 16'h0000, {15'h0, porta_oe[4]});
        $display("test done: pins");
        for (int p = 0; p < 4; p++) begin
            cfg.prescale_select = p[1:0];
            for (int k = 0; k < 2; k++) begin
                c0 = count_ff;
                n = 0;
                while (count_ff === c0 && n < 100) begin
                    tick(1);
                    n++;
                end
            end
            chk("count step", c0 + 16'h0001, count_ff);
            chk("tick interval", 16'(2 * div[p]), 16'(n));
        end
        $display("test done: prescaler");
        for (int s = 0; s < 2; s++) begin
            cfg.capture4_compare5_select = s[0];
            for (int ch = 0; ch < 4; ch++)
                for (int c = 0; c < 4; c++) cap_test(ch, c[1:0]);
        end
        chk("reset out", 16'h0001, {15'h0, reset_out_n});
        $display("test done: captures");
        end_of_test();
    end
endmodule // tb_timer_counter_input_capture

// ---- test/tmr_pin_model.sv ----
// Far-side model of the port A pins: outside event sources
`timescale 1ns/1ps
module tmr_pin_model (
    input  wire logic [7:0] porta_out,
    input  wire logic [7:0] porta_oe,
    output logic [7:0]      porta_in
);
    logic [7:0] ext_lvl;
    // Resolve each pin: the block wins where it drives, else the outside source
    assign porta_in = (porta_oe & porta_out) | (~porta_oe & ext_lvl);
    initial ext_lvl = 8'h00;
    task automatic set_pin(input int b, input logic v);
        ext_lvl[b] = v;
    endtask
endmodule // tmr_pin_model

// ---- verilog/tmr_defines.svh ----
// Constants for the timer, capture and compare block
// What this block does
// R1: Prescaler divides E (system clock over two) by 1, 4, 8 or 16 per code 00..11.
// R2: Sixteen-bit counter starts at zero after reset, counts up to all ones.
// R3: At all ones the counter wraps to zero, sets overflow flag, keeps counting.
// R4: Software has no way to reset, load, alter or stop the counter.
// R5: Three capture, four compare, one shared channel, each with its 16-bit register.
// R6: Every timer function has its own interrupt enable and own request line; RTI and accumulator flags have no enable or line here.
// R7: Event mode counts selected edges on accumulator input in 8-bit counter.
// R8: Gated mode counts internal clock while input holds the chosen level.
// R9: Periodic interrupt rate selectable among four taps of the divider chain.
// R10: Watchdog clocked by E over two to fifteen; timeout drives reset low; chain tap 15 here clocks it at E over two to sixteen.
// R11: Port A bits 0..2 feed captures 3..1; bit 3 shared; bit 7 accumulator.
// R12: Port A bits 3..0 pin levels readable at any time.
// R13: Pins 6..3 used by compare ignore general-purpose output writes.
// R14: Compare channel 1 may drive any combination of port A bits 7..3.
// R15: Selected capture edge latches the counter into that channel's register.
// R16: Capture requests synchronised; latch in half cycle opposite the increment.
// R17: Bit 3 is capture 4 only with select set; reset state is compare 5.
// R18: Bit 3 as output with capture 4 enabled: own writes cause captures.
// R19: Writes to shared register are ignored while it acts as capture 4.
// R20: Edge code 00 off, 01 rising, 10 falling, 11 any edge.
// R21: High-byte read of a capture holds new capture one cycle, value kept.
// R22: Each capture sets its flag; interrupt requested when enabled.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
`define TMR_CNT_RESET   16'h0000
`define TMR_CMP_RESET   16'hffff
`define TMR_CNT_MAX     16'hffff
`define TMR_WDOG_TAP    15
`define TMR_RTI_TAP0    13
`define TMR_PACC_TAP    6
`define TMR_WDOG_LIMIT  3'h7
`endif

// ---- verilog/tmr_pkg.sv ----
// Types shared by the timer block
package tmr_pkg;
    typedef enum logic [1:0] {
        TMR_EDGE_OFF  = 2'b00,
        TMR_EDGE_RISE = 2'b01,
        TMR_EDGE_FALL = 2'b10,
        TMR_EDGE_ANY  = 2'b11
    } tmr_edge_t;
    typedef enum logic [1:0] {
        TMR_PH_INC = 2'b00,
        TMR_PH_CAP = 2'b01
    } tmr_phase_t;
    typedef struct packed {
        logic [1:0] prescale_select;
        logic [1:0] rti_rate;
        logic       capture4_compare5_select;
        logic       pacc_enable;
        logic       pacc_gated;
        logic       pacc_edge_level;
    } tmr_cfg_t;
endpackage

// ---- verilog/tmr_timer.sv ----
// Timer: prescaler, free-running counter, captures, compares, accumulator
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_timer (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire tmr_pkg::tmr_cfg_t cfg,
    input  wire logic [7:0]        edge_sel,
    input  wire logic [7:0]        porta_in,
    input  wire logic [7:0]        porta_gp_out,
    input  wire logic [7:0]        porta_dir,
    input  wire logic [4:0]        cmp_wr,
    input  wire logic [15:0]       cmp_wdata,
    input  wire logic [4:0]        cmp_pin_en,
    input  wire logic [4:0]        cmp_pin_lvl,
    input  wire logic [4:0]        ch1_mask,
    input  wire logic [4:0]        ch1_data,
    input  wire logic [3:0]        cap_hi_rd,
    input  wire logic [8:0]        int_en,
    input  wire logic [8:0]        flag_clr,
    input  wire logic              wdog_service,
    output logic [15:0]            count_ff,
    output logic [15:0]            cap_ff [4],
    output logic [15:0]            cmp_ff [5],
    output logic [7:0]             pacc_ff,
    output logic [8:0]             flag_ff,
    output logic [8:0]             irq,
    output logic [3:0]             porta_level_ff,
    output logic [7:0]             porta_out,
    output logic [7:0]             porta_oe,
    output logic                   reset_out_n
);
    // Flag order: cap1..cap4, cmp1..cmp4(cmp5 shares cap4 slot via select), ovf; rti and pacc flags sit outside flag_ff
    // Index map: 0..3 cap1..4 / cmp5, 4..7 cmp1..4, 8 overflow (rti/pacc below)
    logic [1:0]  ph_ff;
    logic [3:0]  pre_ff;
    // One bit past the counter so the slowest periodic tap exists
    logic [16:0] chain_ff;
    logic        rti_flag_ff;
    logic        pacc_flag_ff;
    logic [2:0]  wdog_ff;
    logic [3:0]  sync1_ff, sync2_ff, prev_ff;
    logic [3:0]  pend_ff, hold_ff;
    logic [7:0]  pa_prev_ff;
    logic [15:0] nxt_count;
    logic [3:0]  pre_mask;
    logic        tick, inc_phase;
    logic [3:0]  cap_pin, cap_edge, cap_ok, fire_vec;
    logic [4:0]  cmp_hit;
    logic        pacc_edge, pacc_tick, rti_tap, wdog_tap, pacc_clk;
    logic [16:0] nxt_chain;

    assign inc_phase = (ph_ff == tmr_pkg::TMR_PH_INC);
    assign pre_mask  = (cfg.prescale_select == 2'b00) ? 4'h0 :
                       (cfg.prescale_select == 2'b01) ? 4'h3 :
                       (cfg.prescale_select == 2'b10) ? 4'h7 : 4'hf; // R1
    assign tick      = inc_phase && ((pre_ff & pre_mask) == 4'h0); // R1
    assign nxt_count = tick ? count_ff + 16'h0001 : count_ff; // R2 R4
    assign nxt_chain = inc_phase ? chain_ff + 17'h00001 : chain_ff;

    // Two-phase stepping: counter moves in one half, captures land in the other
    always_ff @(posedge clk_sys or negedge rstn) begin // R16
        if (!rstn) begin
            ph_ff <= tmr_pkg::TMR_PH_INC;
        end else begin
            ph_ff <= inc_phase ? tmr_pkg::TMR_PH_CAP : tmr_pkg::TMR_PH_INC;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pre_ff   <= 4'h0;
            count_ff <= `TMR_CNT_RESET; // R2
            chain_ff <= 17'h00000;
        end else begin
            pre_ff   <= inc_phase ? pre_ff + 4'h1 : pre_ff;
            count_ff <= nxt_count; // R3
            chain_ff <= nxt_chain;
        end
    end

    // Pin map: bits 2..0 are captures 1..3, bit 3 capture 4 when selected
    assign cap_pin = {(porta_dir[3] ? porta_gp_out[3] : porta_in[3]),
                      porta_in[0], porta_in[1], porta_in[2]}; // R11 R18

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cap
            logic [1:0] code;
            assign code = edge_sel[2*gi+1 -: 2];
            assign cap_edge[gi] = (code == tmr_pkg::TMR_EDGE_RISE && sync2_ff[gi] && !prev_ff[gi])
                               || (code == tmr_pkg::TMR_EDGE_FALL && !sync2_ff[gi] && prev_ff[gi])
                               || (code == tmr_pkg::TMR_EDGE_ANY && (sync2_ff[gi] != prev_ff[gi]));
            // R20
            assign cap_ok[gi] = (gi != 3) || cfg.capture4_compare5_select; // R17
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rstn) begin // R16
        if (!rstn) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            prev_ff  <= 4'h0;
            hold_ff  <= 4'h0;
        end else begin
            sync1_ff <= cap_pin;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
            hold_ff  <= cap_hi_rd; // R21
        end
    end

    // Pending captures wait out the read hold and the increment half
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pend_ff <= 4'h0;
        end else begin
            pend_ff <= (pend_ff | (cap_edge & cap_ok)) & ~fire_vec; // R21
        end
    end
    assign fire_vec = pend_ff & ~hold_ff & ~cap_hi_rd & {4{!inc_phase}}; // R16 R21

    generate
        for (gi = 0; gi < 4; gi++) begin : g_latch
            logic fire;
            assign fire = fire_vec[gi];
            always_ff @(posedge clk_sys) begin
                if (fire) begin
                    cap_ff[gi] <= count_ff; // R15 R16 R21
                end
            end
        end
    endgenerate

    generate
        for (gi = 0; gi < 5; gi++) begin : g_cmp
            logic wr_ok;
            assign wr_ok = cmp_wr[gi] && !(gi == 4 && cfg.capture4_compare5_select); // R19
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    cmp_ff[gi] <= `TMR_CMP_RESET; // R5
                end else if (wr_ok) begin
                    cmp_ff[gi] <= cmp_wdata;
                end
            end
            assign cmp_hit[gi] = tick && (nxt_count == cmp_ff[gi])
                              && !(gi == 4 && cfg.capture4_compare5_select);
        end
    endgenerate

    // Accumulator on pin 7; gated mode uses a slow chain tap
    assign pacc_edge = cfg.pacc_edge_level ? (porta_in[7] && !pa_prev_ff[7])
                                           : (!porta_in[7] && pa_prev_ff[7]);
    assign pacc_clk  = inc_phase && (chain_ff[`TMR_PACC_TAP-1:0] == '0);
    assign pacc_tick = cfg.pacc_enable && (cfg.pacc_gated
                     ? (pacc_clk && (porta_in[7] == cfg.pacc_edge_level)) // R8
                     : pacc_edge); // R7
    assign rti_tap   = nxt_chain[`TMR_RTI_TAP0 + cfg.rti_rate] && !chain_ff[`TMR_RTI_TAP0 + cfg.rti_rate]; // R9
    assign wdog_tap  = nxt_chain[`TMR_WDOG_TAP] && !chain_ff[`TMR_WDOG_TAP]; // R10

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pa_prev_ff  <= 8'h00;
            pacc_ff     <= 8'h00;
            wdog_ff     <= 3'h0;
            rti_flag_ff <= 1'b0;
            pacc_flag_ff <= 1'b0;
        end else begin
            pa_prev_ff   <= porta_in;
            pacc_ff      <= pacc_tick ? pacc_ff + 8'h01 : pacc_ff; // R7 R8
            wdog_ff      <= wdog_service ? 3'h0 : (wdog_tap ? wdog_ff + 3'h1 : wdog_ff); // R10
            rti_flag_ff  <= rti_tap;
            pacc_flag_ff <= pacc_tick && (pacc_ff == 8'hff);
        end
    end
    assign reset_out_n = (wdog_ff != `TMR_WDOG_LIMIT); // R10

    // Set wins over clear on every flag
    logic [8:0] set_vec;
    assign set_vec = {tick && (count_ff == `TMR_CNT_MAX), // R3
                      cmp_hit[3:0],
                      fire_vec[3] || cmp_hit[4],
                      fire_vec[2:0]}; // R22
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flag_ff <= 9'h000;
        end else begin
            flag_ff <= set_vec | (flag_ff & ~flag_clr); // R22
        end
    end
    assign irq = flag_ff & int_en; // R6 R22

    // Compare pins override general writes; channel 1 overrides by mask
    generate
        for (gi = 0; gi < 5; gi++) begin : g_pin
            localparam int PB = gi + 3;
            logic own;
            assign own = cmp_pin_en[gi] && !(gi == 0 && cfg.capture4_compare5_select);
            assign porta_out[PB] = ch1_mask[gi] ? ch1_data[gi] :
                                   own ? cmp_pin_lvl[gi] : porta_gp_out[PB]; // R13 R14
            assign porta_oe[PB]  = ch1_mask[gi] || own || porta_dir[PB];
        end
    endgenerate
    assign porta_out[2:0] = 3'h0;
    assign porta_oe[2:0]  = 3'h0;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            porta_level_ff <= 4'h0;
        end else begin
            porta_level_ff <= porta_in[3:0]; // R12
        end
    end

    AST_WRAP: assert property (@(posedge clk_sys) disable iff (!rstn)
        (tick && count_ff == 16'hffff) |=> (count_ff == 16'h0000 && flag_ff[8])) // R3
        else $error("counter did not wrap with overflow flag");
    AST_NO_TICK_CAP: assert property (@(posedge clk_sys) disable iff (!rstn)
        !inc_phase |=> $stable(count_ff) or $past(tick) == 1'b0) // R16
        else $error("counter moved in capture half");
    AST_STEP: assert property (@(posedge clk_sys) disable iff (!rstn)
        tick |=> count_ff == $past(count_ff) + 16'h0001) // R2
        else $error("counter did not step by one");
    AST_DIV1: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cfg.prescale_select == 2'b00 && inc_phase) |-> tick) // R1
        else $error("divide by one missed a tick");
    AST_SHARED_WR: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cmp_wr[4] && cfg.capture4_compare5_select) |=> $stable(cmp_ff[4])) // R19
        else $error("shared register written in capture mode");
    AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
        cap_hi_rd[0] |=> ##0 $stable(cap_ff[0])) // R21
        else $error("capture changed during high-byte hold");
    AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
        (set_vec[0] && flag_clr[0]) |=> flag_ff[0]) // R22
        else $error("capture flag lost to clear");
    AST_WDOG: assert property (@(posedge clk_sys) disable iff (!rstn)
        wdog_service |=> reset_out_n) // R10
        else $error("watchdog reset after service");
endmodule // tmr_timer
